/* src/scan_window_param_parser.sv */
// The address-and-strobe port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module scan_window_param_parser #(
   parameter int LEN_W = swin_pkg::XFER_LEN_W
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   // command block
   input wire logic i_cmd_start,
   input wire logic [LEN_W-1:0] i_xfer_len,
   // data out phase
   input wire logic i_data_valid,
   input wire logic [7:0] i_data_byte,
   output logic o_data_req,
   // completion
   output logic o_done,
   output logic o_check,
   output logic [3:0] o_sense_key,
   output logic [7:0] o_asc,
   output logic [7:0] o_ascq,
   // register port
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wr_data,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rd_data
);
   if (LEN_W < 8 || LEN_W > 24) begin : g_bad_len
      $error("scan_window_param_parser: LEN_W must be 8 to 24");
   end

   function automatic logic in_rng(input logic [15:0] i, input logic [15:0] lo, input logic [15:0] hi);
      return (i >= lo) && (i <= hi);
   endfunction

   function automatic logic res_ok(input logic [15:0] r, input logic opt);
      if (r == swin_pkg::RES_DEFAULT) begin
         return 1'b1;
      end else if (opt) begin
         return (r >= swin_pkg::RES_MIN) && (r <= swin_pkg::RES_400);
      end else begin
         return (r == swin_pkg::RES_200) || (r == swin_pkg::RES_240) ||
                (r == swin_pkg::RES_300) || (r == swin_pkg::RES_400);
      end
   endfunction

   swin_pkg::parse_state_e st;
   swin_pkg::parse_state_e next_st;
   logic [LEN_W-1:0] remain;
   logic [2:0] hdr_idx;
   logic [15:0] desc_len;
   logic [15:0] desc_idx;
   logic [2:0] store_idx;
   logic err;
   logic [1:0] ctrl;
   logic [3:0] wsel;
   logic [1:0] win_valid;
   logic [7:0] win_id;
   logic [15:0] x_res;
   logic [15:0] y_res;
   logic [31:0] ox;
   logic [31:0] oy;
   logic [31:0] win_w;
   logic [31:0] win_l;
   logic [31:0] mem_q;

   // decode
   wire take = i_data_valid && o_data_req;
   wire last_byte = (remain == LEN_W'(1));
   wire ctrl_opt = ctrl[swin_pkg::CTRL_OPT_BIT];
   wire ctrl_wide = ctrl[swin_pkg::CTRL_WIDE_BIT];
   wire [31:0] x_max = ctrl_wide ? swin_pkg::X_MAX_WIDE : swin_pkg::X_MAX_NARROW;
   wire desc_take = take && (st == swin_pkg::ST_DESC);
   wire desc_end = (desc_idx == desc_len - 16'h0001);
   wire [15:0] next_desc_len = {desc_len[7:0], i_data_byte};
   wire res_good = res_ok(x_res, ctrl_opt) && res_ok(y_res, ctrl_opt);
   wire geo_good = (ox <= x_max) &&
                   (oy <= swin_pkg::Y_MAX) &&
                   (win_w <= x_max) &&
                   (win_l <= swin_pkg::Y_MAX);
   wire fields_good = res_good && geo_good;
   wire mem_we = (st == swin_pkg::ST_STORE);
   wire [3:0] mem_waddr = {win_id[swin_pkg::ID_SIDE_BIT], store_idx};
   wire [31:0] mem_wdata =
      (store_idx == swin_pkg::WORD_XRES) ? {16'h0000, x_res} :
      (store_idx == swin_pkg::WORD_YRES) ? {16'h0000, y_res} :
      (store_idx == swin_pkg::WORD_OX) ? ox :
      (store_idx == swin_pkg::WORD_OY) ? oy :
      (store_idx == swin_pkg::WORD_W) ? win_w : win_l;
   wire busy = (st != swin_pkg::ST_IDLE);
   wire [31:0] rd_mux =
      (i_addr == swin_pkg::REG_CTRL) ? {30'h0, ctrl} :
      (i_addr == swin_pkg::REG_STATUS) ? {28'h0, win_valid, o_check, busy} :
      (i_addr == swin_pkg::REG_WSEL) ? {28'h0, wsel} :
      (i_addr == swin_pkg::REG_WDATA) ? mem_q : 32'h0;

   // next state
   always_comb begin
      next_st = st;
      case (st)
         swin_pkg::ST_IDLE: begin
            if (i_cmd_start && (i_xfer_len != '0)) begin
               next_st = swin_pkg::ST_HDR;
            end
         end
         swin_pkg::ST_HDR: begin
            if (take && last_byte) begin
               next_st = swin_pkg::ST_FINISH;
            end else if (take && hdr_idx == swin_pkg::HDR_LAST) begin
               next_st = (next_desc_len < swin_pkg::MIN_DESC_LEN) ? swin_pkg::ST_DRAIN : swin_pkg::ST_DESC;
            end
         end
         swin_pkg::ST_DESC: begin
            if (take && desc_end) begin
               next_st = swin_pkg::ST_CHECK;
            end else if (take && last_byte) begin
               next_st = swin_pkg::ST_FINISH;
            end
         end
         swin_pkg::ST_CHECK: begin
            if (fields_good) begin
               next_st = swin_pkg::ST_STORE;
            end else if (remain == '0) begin
               next_st = swin_pkg::ST_FINISH;
            end else begin
               next_st = swin_pkg::ST_DESC;
            end
         end
         swin_pkg::ST_STORE: begin
            if (store_idx == swin_pkg::WORD_L) begin
               next_st = (remain == '0) ? swin_pkg::ST_FINISH : swin_pkg::ST_DESC;
            end
         end
         swin_pkg::ST_DRAIN: begin
            if (take && last_byte) begin
               next_st = swin_pkg::ST_FINISH;
            end
         end
         swin_pkg::ST_FINISH: next_st = swin_pkg::ST_IDLE;
         default: next_st = swin_pkg::ST_IDLE;
      endcase
   end

   // sequencer
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         st <= swin_pkg::ST_IDLE;
         o_data_req <= 1'b0;
         remain <= '0;
         hdr_idx <= 3'h0;
         desc_idx <= 16'h0000;
         store_idx <= 3'h0;
         err <= 1'b0;
      end else if (i_clk_en) begin
         st <= next_st;
         o_data_req <= (next_st == swin_pkg::ST_HDR) || (next_st == swin_pkg::ST_DESC) ||
                       (next_st == swin_pkg::ST_DRAIN);
         if (st == swin_pkg::ST_IDLE && i_cmd_start) begin
            remain <= i_xfer_len;
            hdr_idx <= 3'h0;
            err <= 1'b0;
         end else if (take) begin
            remain <= remain - LEN_W'(1);
         end
         if (take && st == swin_pkg::ST_HDR) begin
            hdr_idx <= hdr_idx + 3'h1;
         end
         if (st == swin_pkg::ST_HDR && take && hdr_idx == swin_pkg::HDR_LAST &&
             next_desc_len < swin_pkg::MIN_DESC_LEN) begin
            err <= 1'b1;
         end
         if (st == swin_pkg::ST_CHECK && !fields_good) begin
            err <= 1'b1;
         end
         if (next_st == swin_pkg::ST_DESC && st != swin_pkg::ST_DESC) begin
            desc_idx <= 16'h0000;
         end else if (desc_take) begin
            desc_idx <= desc_idx + 16'h0001;
         end
         store_idx <= mem_we ? store_idx + 3'h1 : 3'h0;
      end
   end

   // header and descriptor field capture, msb first
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         desc_len <= 16'h0000;
         win_id <= 8'h00;
         x_res <= 16'h0000;
         y_res <= 16'h0000;
         ox <= 32'h0;
         oy <= 32'h0;
         win_w <= 32'h0;
         win_l <= 32'h0;
      end else if (i_clk_en) begin
         if (take && st == swin_pkg::ST_HDR && hdr_idx >= swin_pkg::HDR_LEN_MSB) begin
            desc_len <= next_desc_len;
         end
         if (desc_take && desc_idx == swin_pkg::OFS_ID) begin
            win_id <= i_data_byte;
         end
         if (desc_take && in_rng(desc_idx, swin_pkg::OFS_XRES, swin_pkg::OFS_YRES - 16'h1)) begin
            x_res <= {x_res[7:0], i_data_byte};
         end
         if (desc_take && in_rng(desc_idx, swin_pkg::OFS_YRES, swin_pkg::OFS_OX - 16'h1)) begin
            y_res <= {y_res[7:0], i_data_byte};
         end
         if (desc_take && in_rng(desc_idx, swin_pkg::OFS_OX, swin_pkg::OFS_OY - 16'h1)) begin
            ox <= {ox[23:0], i_data_byte};
         end
         if (desc_take && in_rng(desc_idx, swin_pkg::OFS_OY, swin_pkg::OFS_W - 16'h1)) begin
            oy <= {oy[23:0], i_data_byte};
         end
         if (desc_take && in_rng(desc_idx, swin_pkg::OFS_W, swin_pkg::OFS_L - 16'h1)) begin
            win_w <= {win_w[23:0], i_data_byte};
         end
         if (desc_take && in_rng(desc_idx, swin_pkg::OFS_L, swin_pkg::OFS_L_END)) begin
            win_l <= {win_l[23:0], i_data_byte};
         end
      end
   end

   // completion and sense
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_done <= 1'b0;
         o_check <= 1'b0;
         o_sense_key <= swin_pkg::SK_GOOD;
         o_asc <= swin_pkg::ASC_GOOD;
         o_ascq <= swin_pkg::ASC_GOOD;
      end else if (i_clk_en) begin
         o_done <= (st == swin_pkg::ST_FINISH) ||
                   (st == swin_pkg::ST_IDLE && i_cmd_start && i_xfer_len == '0);
         if (st == swin_pkg::ST_FINISH) begin
            o_check <= err;
            o_sense_key <= err ? swin_pkg::SK_ILLEGAL : swin_pkg::SK_GOOD;
            o_asc <= err ? swin_pkg::ASC_BAD_PARAM : swin_pkg::ASC_GOOD;
            o_ascq <= swin_pkg::ASCQ_BAD_PARAM;
         end else if (st == swin_pkg::ST_IDLE && i_cmd_start) begin
            o_check <= 1'b0;
            o_sense_key <= swin_pkg::SK_GOOD;
            o_asc <= swin_pkg::ASC_GOOD;
            o_ascq <= swin_pkg::ASC_GOOD;
         end
      end
   end

   // register port
   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         ctrl <= swin_pkg::CTRL_RESET;
         wsel <= 4'h0;
         win_valid <= 2'h0;
         o_rd_data <= 32'h0;
      end else if (i_clk_en) begin
         if (i_wr && i_addr == swin_pkg::REG_CTRL) begin
            ctrl <= i_wr_data[1:0];
         end
         if (i_wr && i_addr == swin_pkg::REG_WSEL) begin
            wsel <= i_wr_data[3:0];
         end
         if (mem_we && store_idx == swin_pkg::WORD_L) begin
            win_valid[win_id[swin_pkg::ID_SIDE_BIT]] <= 1'b1;
         end
         o_rd_data <= i_rd ? rd_mux : 32'h0;
      end
   end

   win_store #(
      .DW(32),
      .AW(4)
   ) u_store (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_clk_en(i_clk_en),
      .i_we(mem_we),
      .i_waddr(mem_waddr),
      .i_wdata(mem_wdata),
      .i_raddr(wsel),
      .o_rdata(mem_q)
   );

   // checks
   a_zero_len_done: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_clk_en && st == swin_pkg::ST_IDLE && i_cmd_start && i_xfer_len == '0 |=> o_done && !o_check)
      else $error("zero length did not complete good");
   a_zero_no_req: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_clk_en && st == swin_pkg::ST_IDLE && i_cmd_start && i_xfer_len == '0 |=> !o_data_req [*2])
      else $error("zero length asked for data");
   a_drain_end: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      (i_clk_en && take && st == swin_pkg::ST_DRAIN && last_byte) ##1 i_clk_en |=> o_done && o_check)
      else $error("list end not completed");
   a_len_capture: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_clk_en && take && st == swin_pkg::ST_HDR && hdr_idx == swin_pkg::HDR_LAST
      |=> desc_len == {$past(desc_len[7:0]), $past(i_data_byte)})
      else $error("descriptor length not captured");
   a_store_side: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      mem_we |-> mem_waddr[3] == win_id[swin_pkg::ID_SIDE_BIT] && st != swin_pkg::ST_DESC)
      else $error("window stored on wrong side");
   a_store_word: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      mem_we && store_idx == swin_pkg::WORD_OX |-> mem_wdata == ox && mem_waddr[2:0] == swin_pkg::WORD_OX)
      else $error("window word mismatch");
   a_xres_fixed: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_clk_en && st == swin_pkg::ST_CHECK && !ctrl_opt && x_res == 16'h00c7 |=> err && !mem_we)
      else $error("odd x resolution accepted");
   a_yres_fixed: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_clk_en && st == swin_pkg::ST_CHECK && !ctrl_opt && y_res == 16'h0191 |=> err)
      else $error("odd y resolution accepted");
   a_res_option: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_clk_en && st == swin_pkg::ST_CHECK && ctrl_opt && geo_good && x_res == 16'h0064 &&
      y_res == 16'h0065 |=> mem_we)
      else $error("optional resolution refused");
   a_ox_limit: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_clk_en && st == swin_pkg::ST_CHECK && !ctrl_wide && ox == swin_pkg::X_MAX_NARROW + 32'h1 |=> err)
      else $error("x origin over limit accepted");
   a_oy_limit: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_clk_en && st == swin_pkg::ST_CHECK && oy > swin_pkg::Y_MAX |=> err)
      else $error("y origin over limit accepted");
   a_width_limit: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_clk_en && st == swin_pkg::ST_CHECK && ctrl_wide && win_w > swin_pkg::X_MAX_WIDE |=> err)
      else $error("width over limit accepted");
   a_length_limit: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      i_clk_en && st == swin_pkg::ST_CHECK && win_l > swin_pkg::Y_MAX |=> err)
      else $error("length over limit accepted");
   a_sense_code: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
      o_done && o_check |-> o_sense_key == swin_pkg::SK_ILLEGAL && o_asc == swin_pkg::ASC_BAD_PARAM &&
      o_ascq == swin_pkg::ASCQ_BAD_PARAM)
      else $error("wrong sense data");
endmodule

/* src/swin_pkg.sv */
// What this block does
// - transfer length gives the count of parameter bytes sent in data out
// - zero transfer length skips data out and completes with good status
// - descriptor length comes from header bytes 6-7, msb first, steps descriptors
// - all descriptors share one length; bytes from 40 on are vendor bytes
// - fields sit at fixed descriptor offsets: id, auto, resolutions, geometry
// - identifier top bit picks side: below 80h front, 80h up back
// - one window kept per side; initiator uses ids 00h and 80h
// - stored window per side is kept and offered for later use
// - without option x resolution must be 0, 200, 240, 300 or 400
// - without option y resolution must be 0, 200, 240, 300 or 400
// - with option both resolutions accept 0 or 50 to 400
// - x origin limited to 14592 wide model, 10368 narrow model
// - y origin limited to 20736 on both models
// - width limited to 14592 wide model, 10368 narrow model
// - length limited to 20736 on both models
// - bad field gives check at command end, sense key 5, code 26h/00h; later descriptors still parsed and stored
package swin_pkg;
   localparam int XFER_LEN_W = 24;
   // header byte positions
   localparam logic [2:0] HDR_LEN_MSB = 3'h6;
   localparam logic [2:0] HDR_LAST = 3'h7;
   // descriptor byte positions
   localparam logic [15:0] OFS_ID = 16'h0000;
   localparam logic [15:0] OFS_XRES = 16'h0002;
   localparam logic [15:0] OFS_YRES = 16'h0004;
   localparam logic [15:0] OFS_OX = 16'h0006;
   localparam logic [15:0] OFS_OY = 16'h000a;
   localparam logic [15:0] OFS_W = 16'h000e;
   localparam logic [15:0] OFS_L = 16'h0012;
   localparam logic [15:0] OFS_L_END = 16'h0015;
   localparam logic [15:0] OFS_VENDOR = 16'h0028;
   localparam logic [15:0] MIN_DESC_LEN = 16'h0016;
   localparam int ID_SIDE_BIT = 7;
   // resolutions in dpi
   localparam logic [15:0] RES_DEFAULT = 16'h0000;
   localparam logic [15:0] RES_MIN = 16'h0032;
   localparam logic [15:0] RES_200 = 16'h00c8;
   localparam logic [15:0] RES_240 = 16'h00f0;
   localparam logic [15:0] RES_300 = 16'h012c;
   localparam logic [15:0] RES_400 = 16'h0190;
   // geometry limits in 1/1200 inch
   localparam logic [31:0] X_MAX_WIDE = 32'h00003900;
   localparam logic [31:0] X_MAX_NARROW = 32'h00002880;
   localparam logic [31:0] Y_MAX = 32'h00005100;
   // sense data
   localparam logic [3:0] SK_GOOD = 4'h0;
   localparam logic [3:0] SK_ILLEGAL = 4'h5;
   localparam logic [7:0] ASC_GOOD = 8'h00;
   localparam logic [7:0] ASC_BAD_PARAM = 8'h26;
   localparam logic [7:0] ASCQ_BAD_PARAM = 8'h00;
   // register map
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_WSEL = 8'h08;
   localparam logic [7:0] REG_WDATA = 8'h0c;
   localparam int CTRL_OPT_BIT = 0;
   localparam int CTRL_WIDE_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   // stored window words
   localparam logic [2:0] WORD_XRES = 3'h0;
   localparam logic [2:0] WORD_YRES = 3'h1;
   localparam logic [2:0] WORD_OX = 3'h2;
   localparam logic [2:0] WORD_OY = 3'h3;
   localparam logic [2:0] WORD_W = 3'h4;
   localparam logic [2:0] WORD_L = 3'h5;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_HDR = 3'b001,
      ST_DESC = 3'b010,
      ST_CHECK = 3'b011,
      ST_STORE = 3'b100,
      ST_DRAIN = 3'b101,
      ST_FINISH = 3'b110
   } parse_state_e;
endpackage

/* src/win_store.sv */
`timescale 1ns/1ps
module win_store #(
   parameter int DW = 32,
   parameter int AW = 4
) (
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_clk_en,
   // write port
   input wire logic i_we,
   input wire logic [AW-1:0] i_waddr,
   input wire logic [DW-1:0] i_wdata,
   // read port
   input wire logic [AW-1:0] i_raddr,
   output logic [DW-1:0] o_rdata
);
   if (DW < 1 || AW < 1) begin : g_bad_size
      $error("win_store: bad size");
   end

   logic [DW-1:0] mem [0:(1<<AW)-1];

   always_ff @(posedge i_ref_clk) begin
      if (i_clk_en && i_we) begin
         mem[i_waddr] <= i_wdata;
      end
   end

   always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
      if (i_sys_rst) begin
         o_rdata <= '0;
      end else if (i_clk_en) begin
         o_rdata <= mem[i_raddr];
      end
   end
endmodule

/* tb/swin_initiator.sv */
`timescale 1ns/1ps
module swin_initiator (
   // clock
   input wire logic i_ref_clk,
   // data out phase
   input wire logic i_data_req,
   output logic o_data_valid,
   output logic [7:0] o_data_byte
);
   logic [7:0] q[$];
   logic stall = 1'b0;
   initial begin
      o_data_valid = 1'b0;
      o_data_byte = 8'h00;
   end
   // header: junk in reserved bytes, length msb first
   task automatic add_hdr(input logic [15:0] dlen);
      repeat (6) q.push_back(8'h5a);
      q.push_back(dlen[15:8]);
      q.push_back(dlen[7:0]);
   endtask
   // one descriptor, auto flag zero, filler up to dlen
   task automatic add_desc(input logic [7:0] id, input logic [15:0] xr, yr, input logic [31:0] ox, oy, w, l,
      input int dlen);
      logic [159:0] f;
      f = {xr, yr, ox, oy, w, l};
      q.push_back(id);
      q.push_back(8'h00);
      for (int i = 19; i >= 0; i--) q.push_back(f[i*8 +: 8]);
      repeat (dlen - 22) q.push_back(8'hc3);
   endtask
   // each byte held until the edge that takes it
   task automatic send();
      logic took;
      while (q.size() > 0) begin
         if (stall) begin
            o_data_valid <= 1'b0;
            o_data_byte <= ~o_data_byte;
            @(posedge i_ref_clk);
         end
         o_data_valid <= 1'b1;
         o_data_byte <= q.pop_front();
         do begin
            @(negedge i_ref_clk);
            took = i_data_req;
            @(posedge i_ref_clk);
         end while (took !== 1'b1);
      end
      o_data_valid <= 1'b0;
      o_data_byte <= ~o_data_byte;
   endtask
endmodule

/* tb/scan_window_param_parser_tb_top.sv */
`timescale 1ns/1ps
module scan_window_param_parser_tb_top;
   logic i_ref_clk, i_sys_rst, i_clk_en, i_cmd_start, i_wr, i_rd;
   logic [23:0] i_xfer_len;
   logic [7:0] i_addr;
   logic [31:0] i_wr_data, rd;
   logic data_valid, data_req, o_done, o_check;
   logic [7:0] data_byte, o_asc, o_ascq;
   logic [3:0] o_sense_key;
   logic [31:0] o_rd_data;
   int error_cnt = 0;
   int n_tests = 0;

   scan_window_param_parser scan_window_param_parser_i (
      .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .i_clk_en(i_clk_en),
      .i_cmd_start(i_cmd_start), .i_xfer_len(i_xfer_len),
      .i_data_valid(data_valid), .i_data_byte(data_byte), .o_data_req(data_req),
      .o_done(o_done), .o_check(o_check), .o_sense_key(o_sense_key), .o_asc(o_asc), .o_ascq(o_ascq),
      .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd), .o_rd_data(o_rd_data)
   );
   swin_initiator swin_initiator_i (
      .i_ref_clk(i_ref_clk), .i_data_req(data_req), .o_data_valid(data_valid), .o_data_byte(data_byte)
   );

   initial begin
      i_ref_clk = 1'b0;
      forever #50 i_ref_clk = ~i_ref_clk;
   end

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge i_ref_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wr_data <= d;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask

   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge i_ref_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      @(negedge i_ref_clk);
      d = o_rd_data;
   endtask

   // start, send the queued list, wait for completion and judge status
   task automatic run(input logic exp_chk);
      int n;
      @(posedge i_ref_clk);
      i_cmd_start <= 1'b1;
      i_xfer_len <= 24'(swin_initiator_i.q.size());
      @(posedge i_ref_clk);
      i_cmd_start <= 1'b0;
      swin_initiator_i.send();
      n = 0;
      do begin
         @(negedge i_ref_clk);
         n++;
      end while (o_done !== 1'b1 && n < 40);
      check("done", {31'h0, o_done}, 32'h1);
      check("check", {31'h0, o_check}, {31'h0, exp_chk});
      check("sense", {12'h0, o_sense_key, o_asc, o_ascq}, exp_chk ? 32'h52600 : 32'h0);
   endtask

   function automatic logic res_ok(input logic [15:0] r, input logic opt);
      if (r == 16'h0000) return 1'b1;
      if (opt) return r >= 16'h0032 && r <= 16'h0190;
      return r == 16'h00c8 || r == 16'h00f0 || r == 16'h012c || r == 16'h0190;
   endfunction

   task automatic read_win(input logic side, input logic [31:0] v [6]);
      for (int k = 0; k < 6; k++) begin
         bus_wr(swin_pkg::REG_WSEL, {28'h0, side, k[2:0]});
         @(posedge i_ref_clk);
         bus_rd(swin_pkg::REG_WDATA, rd);
         check("window word", rd, v[k]);
      end
   endtask

   // one descriptor list, expectation worked out from the limits
   task automatic one_win(input logic opt, wide, input logic [7:0] id, input logic [15:0] xr, yr,
      input logic [31:0] ox, oy, w, l);
      logic [31:0] xm;
      logic good;
      xm = wide ? 32'h3900 : 32'h2880;
      good = res_ok(xr, opt) && res_ok(yr, opt) && ox <= xm && oy <= 32'h5100 && w <= xm && l <= 32'h5100;
      bus_wr(swin_pkg::REG_CTRL, {30'h0, wide, opt});
      swin_initiator_i.add_hdr(16'h0030);
      swin_initiator_i.add_desc(id, xr, yr, ox, oy, w, l, 48);
      run(!good);
      if (good && xr != 16'h0 && yr != 16'h0) read_win(id[7], '{32'(xr), 32'(yr), ox, oy, w, l});
   endtask

   task automatic t_reset();
      bus_rd(swin_pkg::REG_CTRL, rd);
      check("ctrl reset", rd, 32'h0);
      bus_rd(swin_pkg::REG_STATUS, rd);
      check("status reset", rd, 32'h0);
      bus_rd(8'h40, rd);
      check("unmapped read", rd, 32'h0);
   endtask

   // frozen cycles must ignore a write and a command start
   task automatic t_clk_en();
      @(posedge i_ref_clk);
      i_clk_en <= 1'b0;
      bus_wr(swin_pkg::REG_CTRL, 32'h3);
      @(posedge i_ref_clk);
      i_cmd_start <= 1'b1;
      i_xfer_len <= 24'h0;
      @(posedge i_ref_clk);
      i_cmd_start <= 1'b0;
      @(negedge i_ref_clk);
      check("frozen done", {31'h0, o_done}, 32'h0);
      @(posedge i_ref_clk);
      i_clk_en <= 1'b1;
      bus_rd(swin_pkg::REG_CTRL, rd);
      check("frozen write", rd, 32'h0);
      bus_rd(swin_pkg::REG_STATUS, rd);
      check("frozen start", rd, 32'h0);
      bus_wr(swin_pkg::REG_CTRL, 32'h3);
      bus_rd(swin_pkg::REG_CTRL, rd);
      check("ctrl write", rd, 32'h3);
   endtask

   task automatic t_zero_len();
      run(1'b0);
      check("no data request", {31'h0, data_req}, 32'h0);
   endtask

   task automatic t_hdr_only();
      swin_initiator_i.add_hdr(16'h0030);
      run(1'b0);
   endtask

   task automatic t_two_sides();
      swin_initiator_i.add_hdr(16'h0030);
      swin_initiator_i.add_desc(8'h7f, 16'h00c8, 16'h00f0, 32'h0102, 32'h0304, 32'h0506, 32'h0708, 48);
      swin_initiator_i.add_desc(8'h80, 16'h012c, 16'h0190, 32'h1000, 32'h2000, 32'h2880, 32'h5100, 48);
      run(1'b0);
      read_win(1'b0, '{32'h00c8, 32'h00f0, 32'h0102, 32'h0304, 32'h0506, 32'h0708});
      read_win(1'b1, '{32'h012c, 32'h0190, 32'h1000, 32'h2000, 32'h2880, 32'h5100});
      bus_rd(swin_pkg::REG_STATUS, rd);
      check("both windows held", rd, 32'hc);
   endtask

   task automatic t_res();
      logic [15:0] rv [9] = '{16'h0, 16'h32, 16'hc7, 16'hc8, 16'hf0, 16'h12c, 16'h190, 16'h191, 16'h31};
      for (int o = 0; o < 2; o++) begin
         swin_initiator_i.stall = o[0];
         foreach (rv[i]) begin
            one_win(o[0], 1'b0, 8'h80, rv[i], 16'h00c8, 32'h0, 32'h0, 32'h0, 32'h0);
            one_win(o[0], 1'b0, 8'h01, 16'h00c8, rv[i], 32'h0, 32'h0, 32'h0, 32'h0);
         end
      end
      swin_initiator_i.stall = 1'b0;
   endtask

   task automatic t_geom();
      logic [31:0] xm;
      for (int wd = 0; wd < 2; wd++) begin
         xm = wd ? 32'h3900 : 32'h2880;
         one_win(1'b1, wd[0], 8'h00, 16'h0064, 16'h0065, xm, 32'h5100, xm, 32'h5100);
         one_win(1'b1, wd[0], 8'h00, 16'h0064, 16'h0064, xm + 1, 32'h0, 32'h0, 32'h0);
         one_win(1'b1, wd[0], 8'h80, 16'h0064, 16'h0064, 32'h0, 32'h5101, 32'h0, 32'h0);
         one_win(1'b1, wd[0], 8'h80, 16'h0064, 16'h0064, 32'h0, 32'h0, xm + 1, 32'h0);
         one_win(1'b1, wd[0], 8'h00, 16'h0064, 16'h0064, 32'h0, 32'h0, 32'h0, 32'h5101);
         one_win(1'b0, wd[0], 8'h81, 16'h0190, 16'h0190, 32'h8000_0000, 32'h0, 32'h0, 32'h0);
      end
      one_win(1'b0, 1'b0, 8'h80, 16'h00c8, 16'h00c8, 32'h3900, 32'h0, 32'h0, 32'h0);
   endtask

   task automatic t_short();
      swin_initiator_i.add_hdr(16'h0015);
      repeat (21) swin_initiator_i.q.push_back(8'h00);
      run(1'b1);
   endtask

   initial begin
      i_sys_rst = 1'b1;
      i_clk_en = 1'b1;
      i_cmd_start = 1'b0;
      i_xfer_len = 24'h0;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 8'h0;
      i_wr_data = 32'h0;
      repeat (8) @(posedge i_ref_clk);
      i_sys_rst <= 1'b0;
      t_reset();
      t_clk_en();
      t_zero_len();
      t_hdr_only();
      t_two_sides();
      t_res();
      t_geom();
      t_short();
      give_verdict();
   end

   initial begin
      repeat (20000) @(posedge i_ref_clk);
      error_cnt++;
      give_verdict();
   end
endmodule
